// file: common/timer_pin_io_pkg.sv
// Constants shared by the timer pin function selector
package timer_pin_io_pkg;
   localparam int NSLOT = 4;
   localparam int CNT_W_DEF = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CTRL_W = 8;
   localparam int FIELD_W = 4;
   // Slot 0 is channel 0 register C, slots 1 to 3 are channels 1 to 3 reg A
   localparam int SLOT_CH0C = 0;
   localparam int SLOT_LINK = 1;
   localparam logic [ADDR_W-1:0] OFS_CH1_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CH2_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CH3_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CH0_CTRL_LOW = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CH0_MODE = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATUS = 8'h14;
   localparam logic [NSLOT-1:0][ADDR_W-1:0] CTRL_OFS =
      {OFS_CH3_CTRL, OFS_CH2_CTRL, OFS_CH1_CTRL, OFS_CH0_CTRL_LOW};
   localparam logic [NSLOT-1:0][ADDR_W-1:0] GEN_OFS =
      {8'h24, 8'h20, 8'h1c, 8'h18};
   // Field bit positions and the mode register buffer bit
   localparam int IO_BIT0 = 0;
   localparam int IO_BIT1 = 1;
   localparam int IO_BIT2 = 2;
   localparam int IO_BIT3 = 3;
   localparam int BUF_MODE_A_BIT = 4;
   // Values after reset
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam logic [CTRL_W-1:0] MODE_RST = 8'h00;
   localparam logic PIN_LEVEL_RST = 1'b0;
   localparam logic PIN_OE_RST = 1'b1;
   // Pin actions of the compare modes, bits 1:0 of the field
   localparam logic [1:0] ACT_HOLD = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   // Capture edges, bits 1:0 of the field
   localparam logic [1:0] CAP_RISE = 2'h0;
   localparam logic [1:0] CAP_FALL = 2'h1;
endpackage : timer_pin_io_pkg

// file: rtl/pin_out_ctl.sv
// Compare-mode pin driver for one timer channel register
`timescale 1ns/1ps
module pin_out_ctl
   import timer_pin_io_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [FIELD_W-1:0] field,
   input wire logic field_written,
   input wire logic match,
   input wire logic off,
   output logic pin_o,
   output logic pin_oe
);
   typedef struct packed {
      logic level;
      logic oe;
   } out_st_t;

   out_st_t q;
   out_st_t d;

   always_comb
   begin
      d = q;
      d.oe = !field[IO_BIT3];
      if (!field[IO_BIT3] && !off)
      begin
         // A fresh setting wins over a match in the same cycle
         if (field_written)
         begin
            if (field[IO_BIT1:IO_BIT0] != ACT_HOLD)
               d.level = field[IO_BIT2];
         end
         else if (match)
         begin
            unique case (field[IO_BIT1:IO_BIT0])
               ACT_HOLD: d.level = q.level;
               ACT_LOW: d.level = 1'b0;
               ACT_HIGH: d.level = 1'b1;
               ACT_TOGGLE: d.level = !q.level;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '{level: PIN_LEVEL_RST, oe: PIN_OE_RST};
      else
         q <= d;
   end

   assign pin_o = q.level;
   assign pin_oe = q.oe;
endmodule : pin_out_ctl

// file: rtl/capture_ctl.sv
// Input capture trigger for one timer channel register
`timescale 1ns/1ps
module capture_ctl
   import timer_pin_io_pkg::*;
#(
   parameter bit LINK = 1'b0
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [FIELD_W-1:0] field,
   input wire logic link_evt,
   input wire logic pin_i,
   input wire logic off,
   output logic hit
);
   typedef struct packed {
      logic prev;
      logic valid;
   } cap_st_t;

   cap_st_t q;
   cap_st_t d;
   logic rise;
   logic fall;

   // No edge is seen in the first cycle after reset: prev is not yet known
   assign rise = q.valid && pin_i && !q.prev;
   assign fall = q.valid && !pin_i && q.prev;

   always_comb
   begin
      d.prev = pin_i;
      d.valid = 1'b1;
      hit = 1'b0;
      if (field[IO_BIT3] && !off)
      begin
         if (LINK && field[IO_BIT2])
            hit = link_evt;
         else if (field[IO_BIT1])
            hit = rise || fall;
         else if (field[IO_BIT0] == CAP_FALL[0])
            hit = fall;
         else
            hit = rise;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end
endmodule : capture_ctl

// file: rtl/timer_pin_io.sv
// Pin function selector for timer channel 1-3 reg A and channel 0 reg C
// How it works
// - Hold mode never changes the pin; after reset the pin stays low.
// - Compare mode 01 drives the pin low on each compare match.
// - Compare mode 10 drives the pin high on each compare match.
// - Compare mode 11 toggles the pin on each compare match.
// - Capture mode 00 loads the counter on a rising pin edge.
// - Capture mode 01 loads the counter on a falling pin edge.
// - Capture mode 1x loads the counter on both pin edges.
// - Channel 1 with bits 3 and 2 set captures on channel 0 reg A events.
// - Buffer mode A stops channel 0 reg C from moving its pin or capturing; its pin_oe still follows bit 3.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module timer_pin_io
   import timer_pin_io_pkg::*;
#(
   parameter int CNT_W = CNT_W_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [DATA_W-1:0] rdata,
   input wire logic [NSLOT-1:0][CNT_W-1:0] counter,
   input wire logic [NSLOT-1:0] match,
   input wire logic ch0_event_a,
   input wire logic [NSLOT-1:0] pin_i,
   output logic [NSLOT-1:0] pin_o,
   output logic [NSLOT-1:0] pin_oe,
   output logic [NSLOT-1:0][CNT_W-1:0] general_reg,
   output logic [NSLOT-1:0] capture_evt
);
   generate
      if (CNT_W < 1 || CNT_W > DATA_W)
      begin : g_bad_width
         $error("timer_pin_io: CNT_W must be 1 to 32");
      end
   endgenerate

   typedef struct packed {
      logic [NSLOT-1:0][CTRL_W-1:0] ctrl;
      logic [CTRL_W-1:0] mode;
      logic [NSLOT-1:0][CNT_W-1:0] gen;
      logic [NSLOT-1:0] written;
      logic [NSLOT-1:0] cap_evt;
      logic [DATA_W-1:0] rdata;
   } top_st_t;

   top_st_t q;
   top_st_t d;
   logic [NSLOT-1:0] off;
   logic [NSLOT-1:0] hit;
   logic [NSLOT-1:0][FIELD_W-1:0] field;

   // Only channel 0 reg C can serve as a buffer
   always_comb
   begin
      off = '0;
      off[SLOT_CH0C] = q.mode[BUF_MODE_A_BIT];
   end

   genvar gi;
   generate
      for (gi = 0; gi < NSLOT; gi++)
      begin : g_slot
         assign field[gi] = q.ctrl[gi][FIELD_W-1:0];

         pin_out_ctl u_out (
            .clk(clk),
            .rst_n(rst_n),
            .field(field[gi]),
            .field_written(q.written[gi]),
            .match(match[gi]),
            .off(off[gi]),
            .pin_o(pin_o[gi]),
            .pin_oe(pin_oe[gi])
         );

         capture_ctl #(
            .LINK(gi == SLOT_LINK)
         ) u_cap (
            .clk(clk),
            .rst_n(rst_n),
            .field(field[gi]),
            .link_evt(ch0_event_a),
            .pin_i(pin_i[gi]),
            .off(off[gi]),
            .hit(hit[gi])
         );
      end
   endgenerate

   always_comb
   begin
      d = q;
      d.rdata = '0;
      for (int i = 0; i < NSLOT; i++)
      begin
         d.written[i] = wr && (addr == CTRL_OFS[i]);
         if (d.written[i])
            d.ctrl[i] = wdata[CTRL_W-1:0];
         if (wr && (addr == GEN_OFS[i]))
            d.gen[i] = wdata[CNT_W-1:0];
         // A capture in the same cycle as a software write wins
         if (hit[i])
            d.gen[i] = counter[i];
         d.cap_evt[i] = hit[i];
      end
      if (wr && (addr == OFS_CH0_MODE))
         d.mode = wdata[CTRL_W-1:0];
      if (rd)
      begin
         for (int i = 0; i < NSLOT; i++)
         begin
            if (addr == CTRL_OFS[i])
               d.rdata = {{(DATA_W-CTRL_W){1'b0}}, q.ctrl[i]};
            if (addr == GEN_OFS[i])
               d.rdata[CNT_W-1:0] = q.gen[i];
         end
         if (addr == OFS_CH0_MODE)
            d.rdata = {{(DATA_W-CTRL_W){1'b0}}, q.mode};
         if (addr == OFS_PIN_STATUS)
            d.rdata = {{(DATA_W-2*NSLOT){1'b0}}, pin_oe, pin_o};
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         q.ctrl <= {NSLOT{CTRL_RST}};
         q.mode <= MODE_RST;
         q.gen <= '0;
         q.written <= '0;
         q.cap_evt <= '0;
         q.rdata <= '0;
      end
      else
         q <= d;
   end

   assign rdata = q.rdata;
   assign general_reg = q.gen;
   assign capture_evt = q.cap_evt;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // Pin stays low as reset is released
   a_reset_pin_low: assert property (
      $rose(rst_n) |-> (pin_o == '0) && (pin_oe == '1)
   ) else $error("pin not low after reset");

   // Read data appear in the cycle after the strobe and only there
   a_read_ctrl_data: assert property (
      rd && (addr == OFS_CH1_CTRL)
      |=> rdata == {{(DATA_W-CTRL_W){1'b0}}, $past(q.ctrl[SLOT_LINK])}
   ) else $error("control read returned wrong value");

   a_read_idle_zero: assert property (
      !rd |=> rdata == '0
   ) else $error("read data not zero without a read");

   // Channel 0 reg C stays quiet while it serves as a buffer
   a_buffer_no_capture: assert property (
      off[SLOT_CH0C] |=> !capture_evt[SLOT_CH0C]
   ) else $error("buffer register produced a capture");

   a_buffer_pin_still: assert property (
      off[SLOT_CH0C] |=> $stable(pin_o[SLOT_CH0C])
   ) else $error("buffer register moved its pin");

   // Channel 0 reg A events reach channel 1 in link capture mode
   a_link_capture: assert property (
      field[SLOT_LINK][IO_BIT3] && field[SLOT_LINK][IO_BIT2] && ch0_event_a
      |=> capture_evt[SLOT_LINK]
          && general_reg[SLOT_LINK] == $past(counter[SLOT_LINK])
   ) else $error("link event did not capture");

   // Channel 1 in link mode no longer looks at its own pin
   a_link_ignores_pin: assert property (
      field[SLOT_LINK][IO_BIT3] && field[SLOT_LINK][IO_BIT2] && !ch0_event_a
      |=> !capture_evt[SLOT_LINK]
   ) else $error("link mode captured without an event");

   // Reset clears read data, capture pulses and general registers too
   a_reset_outputs_clear: assert property (
      $rose(rst_n) |-> rdata == '0 && capture_evt == '0
         && general_reg == '0
   ) else $error("outputs not cleared by reset");

   // Mode and pin status reads keep the one-cycle read timing
   a_read_mode_data: assert property (
      rd && (addr == OFS_CH0_MODE)
      |=> rdata == {{(DATA_W-CTRL_W){1'b0}}, $past(q.mode)}
   ) else $error("mode read returned wrong value");

   a_read_pin_status: assert property (
      rd && (addr == OFS_PIN_STATUS)
      |=> rdata == {{(DATA_W-2*NSLOT){1'b0}}, $past(pin_oe), $past(pin_o)}
   ) else $error("pin status read returned wrong value");

   // Decoder of every mapped offset; anything else must read as zero
   logic addr_known;

   always_comb
   begin
      addr_known = (addr == OFS_CH0_MODE) || (addr == OFS_PIN_STATUS);
      for (int i = 0; i < NSLOT; i++)
      begin
         if (addr == CTRL_OFS[i] || addr == GEN_OFS[i])
            addr_known = 1'b1;
      end
   end

   a_read_unmapped_zero: assert property (
      rd && !addr_known |=> rdata == '0
   ) else $error("unmapped read returned data");

   generate
      for (gi = 0; gi < NSLOT; gi++)
      begin : g_chk
         logic cmp_go;
         logic cap_go;
         logic link_sel;

         assign link_sel = (gi == SLOT_LINK) && field[gi][IO_BIT2];
         assign cmp_go = !field[gi][IO_BIT3] && match[gi]
            && !q.written[gi] && !off[gi];
         assign cap_go = field[gi][IO_BIT3] && !link_sel && !off[gi];

         sequence s_rise;
            (rst_n && !pin_i[gi]) ##1 pin_i[gi];
         endsequence

         sequence s_fall;
            (rst_n && pin_i[gi]) ##1 !pin_i[gi];
         endsequence

         sequence s_cap_taken;
            ##1 capture_evt[gi] && general_reg[gi] == $past(counter[gi]);
         endsequence

         a_hold_pin_still: assert property (
            !field[gi][IO_BIT3]
            && field[gi][IO_BIT1:IO_BIT0] == ACT_HOLD
            |=> $stable(pin_o[gi])
         ) else $error("pin moved in hold mode");

         a_match_drive_low: assert property (
            cmp_go && field[gi][IO_BIT1:IO_BIT0] == ACT_LOW
            |=> !pin_o[gi]
         ) else $error("pin not low after match");

         a_match_drive_high: assert property (
            cmp_go && field[gi][IO_BIT1:IO_BIT0] == ACT_HIGH
            |=> pin_o[gi]
         ) else $error("pin not high after match");

         a_match_toggle_pin: assert property (
            cmp_go && field[gi][IO_BIT1:IO_BIT0] == ACT_TOGGLE
            |=> pin_o[gi] != $past(pin_o[gi])
         ) else $error("pin did not toggle on match");

         a_initial_pin_level: assert property (
            q.written[gi] && !off[gi] && !field[gi][IO_BIT3]
            && field[gi][IO_BIT1:IO_BIT0] != ACT_HOLD
            |=> pin_o[gi] == $past(field[gi][IO_BIT2]) && pin_oe[gi]
         ) else $error("initial pin level not driven");

         a_rise_capture: assert property (
            (s_rise ##0 (cap_go && !field[gi][IO_BIT1]
               && field[gi][IO_BIT0] == CAP_RISE[0]))
            |-> s_cap_taken
         ) else $error("rising edge not captured");

         a_fall_capture: assert property (
            (s_fall ##0 (cap_go && !field[gi][IO_BIT1]
               && field[gi][IO_BIT0] == CAP_FALL[0]))
            |-> s_cap_taken
         ) else $error("falling edge not captured");

         a_both_capture: assert property (
            ((s_rise or s_fall) ##0 (cap_go && field[gi][IO_BIT1]))
            |-> s_cap_taken
         ) else $error("edge not captured in both-edge mode");

         a_cap_quiet_pin: assert property (
            cap_go && $stable(pin_i[gi]) && $past(rst_n)
            |=> !capture_evt[gi]
         ) else $error("capture without a pin edge");

         a_capture_no_drive: assert property (
            field[gi][IO_BIT3] |=> !pin_oe[gi]
         ) else $error("pin driven in capture mode");

         a_compare_drives_pin: assert property (
            !field[gi][IO_BIT3] |=> pin_oe[gi]
         ) else $error("pin not driven in compare mode");

         a_compare_no_capture: assert property (
            !field[gi][IO_BIT3] |=> !capture_evt[gi]
         ) else $error("capture while in compare mode");

         // Between matches and writes the compare pin keeps its level
         a_idle_pin_still: assert property (
            !field[gi][IO_BIT3] && !match[gi] && !q.written[gi]
            |=> $stable(pin_o[gi])
         ) else $error("pin moved without a match");

         // A capture takes the counter even against a same-cycle write
         a_capture_loads_count: assert property (
            hit[gi]
            |=> capture_evt[gi] && general_reg[gi] == $past(counter[gi])
         ) else $error("capture did not load the counter");

         a_gen_write_lands: assert property (
            wr && (addr == GEN_OFS[gi]) && !hit[gi]
            |=> general_reg[gi] == $past(wdata[CNT_W-1:0])
         ) else $error("general register write lost");

         a_gen_reg_still: assert property (
            !hit[gi] && !(wr && (addr == GEN_OFS[gi]))
            |=> $stable(general_reg[gi])
         ) else $error("general register changed on its own");

         a_ctrl_write_lands: assert property (
            wr && (addr == CTRL_OFS[gi])
            |=> q.ctrl[gi] == $past(wdata[CTRL_W-1:0])
         ) else $error("control write lost");

         a_read_ctrl_slot: assert property (
            rd && (addr == CTRL_OFS[gi])
            |=> rdata == {{(DATA_W-CTRL_W){1'b0}}, $past(q.ctrl[gi])}
         ) else $error("control readback wrong");

         a_read_gen_slot: assert property (
            rd && (addr == GEN_OFS[gi])
            |=> rdata == DATA_W'($past(general_reg[gi]))
         ) else $error("general register read returned wrong value");
      end
   endgenerate
endmodule : timer_pin_io

// file: tb/pin_partner.sv
// Far-side pin model: a driven pin reads back, else the outside level
`timescale 1ns/1ps
module pin_partner
   import timer_pin_io_pkg::*;
(
   input wire logic [NSLOT-1:0] pin_o,
   input wire logic [NSLOT-1:0] pin_oe,
   input wire logic [NSLOT-1:0] ext_level,
   output logic [NSLOT-1:0] pin_i
);
   // Outside source is weak, so the block wins whenever it drives
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_level);
endmodule : pin_partner

// file: tb/tb_top.sv
// Self-checking bench for the timer pin function selector
`timescale 1ns/1ps
module tb_top
   import timer_pin_io_pkg::*;
;
   logic clk, rst_n, wr, rd, ch0_event_a;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d, w;
   logic [NSLOT-1:0][CNT_W_DEF-1:0] counter, general_reg;
   logic [NSLOT-1:0] match, pin_i, pin_o, pin_oe, capture_evt, ext, lvl;
   logic [CNT_W_DEF-1:0] n;
   int err_count, samples_checked;

   timer_pin_io u_timer_pin_io (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .counter(counter),
      .match(match), .ch0_event_a(ch0_event_a), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe(pin_oe), .general_reg(general_reg),
      .capture_evt(capture_evt));
   pin_partner u_pin_partner (.pin_o(pin_o), .pin_oe(pin_oe),
      .ext_level(ext), .pin_i(pin_i));

   always #2.5 clk = ~clk;

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(logic [ADDR_W-1:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg

   // Level a compare match leaves behind
   function automatic logic nxt(logic [3:0] f, logic cur);
      case (f[1:0])
         ACT_LOW: return 1'b0;
         ACT_HIGH: return 1'b1;
         ACT_TOGGLE: return ~cur;
         default: return cur;
      endcase
   endfunction : nxt

   // Write a compare field, then pulse match k times; frz models buffer
   task automatic cmp(int s, logic [3:0] f, int k, bit frz);
      wr_reg(CTRL_OFS[s], {28'h0, f});
      if (f[1:0] != ACT_HOLD && !frz)
         lvl[s] = f[2];
      @(posedge clk);
      @(negedge clk);
      chk("pin_init", lvl[s], pin_o[s]);
      chk("pin_oe", 1'b1, pin_oe[s]);
      repeat (k)
      begin
         @(posedge clk);
         match[s] <= 1'b1;
         @(posedge clk);
         match[s] <= 1'b0;
         if (!frz)
            lvl[s] = nxt(f, lvl[s]);
         @(negedge clk);
         chk("pin_match", lvl[s], pin_o[s]);
      end
   endtask : cmp

   // One pin step on slot s; hit tells whether a capture must follow
   task automatic step(int s, bit hit);
      n = CNT_W_DEF'($urandom);
      @(posedge clk);
      ext[s] <= ~ext[s];
      counter[s] <= n;
      @(posedge clk);
      @(negedge clk);
      chk("cap_evt", hit, capture_evt[s]);
      if (hit)
         chk("cap_val", n, general_reg[s]);
   endtask : step

   task automatic cap(int s, logic [3:0] f, bit frz);
      wr_reg(CTRL_OFS[s], {28'h0, f});
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("pin_oe_cap", 1'b0, pin_oe[s]);
      for (int j = 0; j < 4; j++)
         step(s, !frz && (f[1] || (f[0] == ext[s])));
   endtask : cap

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {wr, rd, ch0_event_a} = 3'h0;
      addr = '0;
      wdata = '0;
      counter = '0;
      match = '0;
      ext = '0;
      lvl = '0;
      void'($urandom(32'h7097));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("rst_pin", 4'h0, pin_o);
      for (int s = 0; s < NSLOT; s++)
      begin
         cmp(s, 4'h4, 2, 1'b0);
         w = $urandom;
         wr_reg(CTRL_OFS[s], w);
         // A random compare field drives its initial level at once
         if (!w[3] && w[1:0] != ACT_HOLD)
            lvl[s] = w[2];
         rd_reg(CTRL_OFS[s]);
         chk("ctrl_rb", {24'h0, w[7:0]}, d);
      end
      rd_reg(8'h30);
      chk("unmapped", 32'h0, d);
      for (int s = 0; s < NSLOT; s++)
         for (int f = 0; f < 8; f++)
            cmp(s, 4'(f), 2, 1'b0);
      repeat (20)
         cmp($urandom_range(3), 4'($urandom_range(7)),
            $urandom_range(1, 3), 1'b0);
      for (int s = 1; s < NSLOT; s++)
         for (int m = 0; m < 4; m++)
            cap(s, {2'b10, 2'(m)} | (s > 1 ? 4'($urandom) & 4'h4 : 4'h0),
               1'b0);
      // Channel 1 follows channel 0 events and no longer its pin
      wr_reg(OFS_CH1_CTRL, 32'h0c);
      n = CNT_W_DEF'($urandom);
      @(posedge clk);
      ch0_event_a <= 1'b1;
      counter[1] <= n;
      @(posedge clk);
      ch0_event_a <= 1'b0;
      @(negedge clk);
      chk("link_evt", 1'b1, capture_evt[1]);
      chk("link_val", n, general_reg[1]);
      step(1, 1'b0);
      // Second reset in mid-run: pins low and driven, registers cleared
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      lvl = '0;
      @(negedge clk);
      chk("rst_pin2", 4'h0, pin_o);
      chk("rst_gen", 16'h0, general_reg[1]);
      rd_reg(OFS_PIN_STATUS);
      chk("status", 32'hf0, d);
      rd_reg(OFS_CH1_CTRL);
      chk("rst_ctrl", 32'h0, d);
      w = $urandom;
      wr_reg(GEN_OFS[2], w);
      rd_reg(GEN_OFS[2]);
      chk("gen_rb", {16'h0, w[15:0]}, d);
      // Buffer mode: slot 0 frozen and silent whatever its field says
      cmp(0, 4'h6, 1, 1'b0);
      wr_reg(OFS_CH0_MODE, 32'h10);
      rd_reg(OFS_CH0_MODE);
      chk("mode_rb", 32'h10, d);
      cmp(0, 4'h1, 2, 1'b1);
      cmp(0, 4'h3, 2, 1'b1);
      cap(0, 4'ha, 1'b1);
      wr_reg(OFS_CH0_MODE, 32'h0);
      cap(0, 4'ha, 1'b0);
      give_verdict();
   end

   // Whole run is under a thousand cycles; this cuts off a hang
   initial
   begin
      #200000;
      err_count++;
      give_verdict();
   end
endmodule : tb_top
